// >>> verilog/acc_control.sv
// apb register file and digital control around the analog comparator
`timescale 1ns/100ps
`include "acc_defines.svh"

// Notes on behaviour
// R1: buffer-off bit one disables pin buffer
// R2: bit n controls port pin n
// R3: result high when plus exceeds minus
// R4: powered off forces result low
// R5: exchange swaps inputs and inverts result
// R6: each terminal switch controlled independently
// R7: short bit connects both terminals
// R8: filter bit selects filtered result
// R9: level field drives reference generator
// R10: terminal select routes reference voltage
// R11: disable kills input and output buffer
// R12: switched comparator pins always buffer-off
// R13: pending set on selected result edge
// R14: request needs module and global enable
// R15: pending clears on service or write
// R16: one flag and one request line
// R17: result feeds timer capture input
// R18: edge select zero rising one falling
// R19: result status bit is read only
// R20: synchronise result before edge detect
// R21: everything resets to zero
module acc_control
    import acc_pkg::*;
#(
    parameter int PORT_WIDTH = 8,
    parameter int FILTER_CYCLES = `ACC_FILTER_CYCLES
)
(
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [`ACC_ADDR_WIDTH-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // analog front end
    input wire logic RAW_COMPARE_IN,
    output logic COMPARATOR_POWER_ON_OUT,
    output logic INPUT_EXCHANGE_OUT,
    output logic INPUT_SHORT_OUT,
    output logic [1:0] INPUT_SWITCH_SELECT_OUT,
    output logic [1:0] REFERENCE_LEVEL_SELECT_OUT,
    output logic REFERENCE_TO_MINUS_OUT,
    // port pins and timer
    output logic [PORT_WIDTH-1:0] PIN_BUFFER_OFF_OUT,
    output logic COMPARATOR_RESULT_OUT,
    // processor interrupt side
    input wire logic GLOBAL_IRQ_ENABLE_IN,
    input wire logic IRQ_SERVICED_IN,
    output logic IRQ_REQUEST_OUT
);

    // pin positions of the two comparator terminals on the port
    // moving a terminal to another pin only means changing its number here
    localparam int SWITCH0_PIN = 0;
    localparam int SWITCH1_PIN = 1;

    // elaboration check: register and switch pins must fit an 8-bit port
    // a wider port would need a second byte lane in the buffer disable word
    if (PORT_WIDTH < 2 || PORT_WIDTH > 8 || FILTER_CYCLES < 1 || FILTER_CYCLES > 255)
    begin : g_bad_param
        $error("acc_control: unsupported parameter value");
    end

    // control state
    logic exchange_ff;  // swap terminals, invert result
    logic ref_term_ff;  // reference terminal choice
    acc_ref_type ref_level_ff;  // reference generator level
    logic power_ff;  // comparator powered
    logic edge_ff;  // 0 rising, 1 falling
    logic irq_en_ff;  // module interrupt enable
    logic pending_ff;  // interrupt pending flag
    logic filter_ff;  // filter enable
    logic [1:0] switch_ff;  // terminal switches
    logic short_ff;  // input short switch
    logic [PORT_WIDTH-1:0] pad_off_ff;  // per-pin buffer disable

    // result path
    logic sync1_ff;  // first synchroniser stage
    logic sync2_ff;  // second synchroniser stage
    logic [7:0] filt_cnt_ff;  // filter stability counter
    logic filt_ff;  // filtered raw value
    logic result_ff;  // presented result
    logic result_prev_ff;  // result one cycle ago
    logic nxt_result;  // next presented result

    // bus decode; every hit is a combinational compare of the held address
    logic wr_en;  // write takes effect this cycle
    logic hit_c1;  // control one word addressed
    logic hit_c2;  // control two word addressed
    logic hit_pad;  // buffer disable word addressed
    // pending flag side channels
    logic wr_pending_clear;  // software writes zero to the flag
    logic edge_seen;  // qualifying result edge this cycle
    // read side byte views
    logic [7:0] rd_byte;  // selected register byte
    logic [7:0] c1_byte;  // control one as read
    logic [7:0] c2_byte;  // control two as read

    // address compare used by both read and write decode
    function automatic logic addr_is(input logic [`ACC_ADDR_WIDTH-1:0] a,
                                     input logic [`ACC_ADDR_WIDTH-1:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    // zero wait state slave; the lowest byte lane carries every register
    assign PREADY_OUT = 1'b1;
    assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & PSTRB_IN[0];
    assign hit_c1 = addr_is(PADDR_IN, `ACC_CTRL1_OFFSET);
    assign hit_c2 = addr_is(PADDR_IN, `ACC_CTRL2_OFFSET);
    assign hit_pad = addr_is(PADDR_IN, `ACC_PAD_OFFSET);
    // unmapped addresses answer with an error, never change state
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~(hit_c1 | hit_c2 | hit_pad);

    // control register one fields
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            exchange_ff <= 1'b0;  // R21
            ref_term_ff <= 1'b0;
            ref_level_ff <= ACC_REF_OFF;
            power_ff <= 1'b0;
            edge_ff <= 1'b0;
            irq_en_ff <= 1'b0;
        end
        else if (wr_en && hit_c1)
        begin
            exchange_ff <= PWDATA_IN[`ACC_C1_EXCHANGE];
            ref_term_ff <= PWDATA_IN[`ACC_C1_REF_TERM];
            ref_level_ff <= acc_ref_type'(PWDATA_IN[`ACC_C1_REF_HI:`ACC_C1_REF_LO]);  // R9
            power_ff <= PWDATA_IN[`ACC_C1_POWER];
            edge_ff <= PWDATA_IN[`ACC_C1_EDGE];  // R18
            irq_en_ff <= PWDATA_IN[`ACC_C1_IRQ_EN];
        end
    end

    // control register two; the result bit is not stored so writes to it vanish
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            filter_ff <= 1'b0;
            switch_ff <= 2'h0;
            short_ff <= 1'b0;
        end
        else if (wr_en && hit_c2)
        begin
            filter_ff <= PWDATA_IN[`ACC_C2_FILTER];  // R8
            switch_ff <= PWDATA_IN[`ACC_C2_SWITCH1:`ACC_C2_SWITCH0];  // R6
            short_ff <= PWDATA_IN[`ACC_C2_SHORT];  // R7
        end
    end

    // port buffer disable register
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            pad_off_ff <= PORT_WIDTH'(`ACC_PAD_RESET);
        end
        else if (wr_en && hit_pad)
        begin
            pad_off_ff <= PWDATA_IN[PORT_WIDTH-1:0];  // R1
        end
    end

    // two-flop synchroniser; the analog output is fully asynchronous
    // only the second stage feeds logic, so a metastable first stage stays contained
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= RAW_COMPARE_IN;  // R20
            sync2_ff <= sync1_ff;
        end
    end

    // digital stand-in for the rc filter: follow only after a stable run,
    // which hides chatter near the threshold at the cost of some delay
    // any disagreement that breaks off early restarts the count from zero
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            filt_cnt_ff <= 8'h00;
            filt_ff <= 1'b0;
        end
        else if (sync2_ff == filt_ff)
        begin
            filt_cnt_ff <= 8'h00;
        end
        else if (filt_cnt_ff >= 8'(FILTER_CYCLES - 1))
        begin
            filt_cnt_ff <= 8'h00;
            filt_ff <= sync2_ff;
        end
        else
        begin
            filt_cnt_ff <= filt_cnt_ff + 8'h01;
        end
    end

    // presented result: filter choice, exchange inversion, power gating
    always_comb
    begin
        nxt_result = filter_ff ? filt_ff : sync2_ff;  // R8
        nxt_result = nxt_result ^ exchange_ff;  // R5
        nxt_result = nxt_result & power_ff;  // R4
    end

    // result register; raw input is high when plus exceeds minus
    // both copies reset low together, so leaving reset makes no false edge
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            result_ff <= 1'b0;
            result_prev_ff <= 1'b0;
        end
        else
        begin
            result_ff <= nxt_result;  // R3
            result_prev_ff <= result_ff;
        end
    end

    // edge select picks rising or falling transition of the result
    assign edge_seen = edge_ff ? (result_prev_ff & ~result_ff)
                               : (~result_prev_ff & result_ff);  // R13

    // writing zero to the flag bit is the software clear; writing one sets it
    assign wr_pending_clear = wr_en & hit_c1 & ~PWDATA_IN[`ACC_C1_PENDING];

    // single pending flag; a new edge wins over a clear in the same cycle
    // a service pulse and a software write of zero clear it alike
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            pending_ff <= 1'b0;
        end
        else if (edge_seen)
        begin
            pending_ff <= 1'b1;  // R13
        end
        else if (wr_en && hit_c1 && PWDATA_IN[`ACC_C1_PENDING])
        begin
            pending_ff <= 1'b1;  // software may raise it to test the handler
        end
        else if (IRQ_SERVICED_IN || wr_pending_clear)
        begin
            pending_ff <= 1'b0;  // R15
        end
    end

    // one request line for every comparator event
    // the processor's global enable is anded in here, and the request itself is never latched here
    assign IRQ_REQUEST_OUT = pending_ff & irq_en_ff & GLOBAL_IRQ_ENABLE_IN;  // R14 R16

    // analog controls go straight out of their registers, except the reference side, which is xored with exchange
    assign COMPARATOR_POWER_ON_OUT = power_ff;
    assign INPUT_EXCHANGE_OUT = exchange_ff;  // R5
    assign INPUT_SHORT_OUT = short_ff;  // R7
    assign INPUT_SWITCH_SELECT_OUT = switch_ff;  // R6
    assign REFERENCE_LEVEL_SELECT_OUT = ref_level_ff;  // R9
    // the analog mux swaps terminals, so exchange flips the reference side
    assign REFERENCE_TO_MINUS_OUT = ref_term_ff ^ exchange_ff;  // R10
    assign COMPARATOR_RESULT_OUT = result_ff;  // R17

    // per-pin buffer disable, forced for pins routed to the comparator
    genvar gi;
    generate
        for (gi = 0; gi < PORT_WIDTH; gi++)
        begin : g_pin
            if (gi == SWITCH0_PIN)
            begin : g_sw0
                assign PIN_BUFFER_OFF_OUT[gi] = pad_off_ff[gi] | switch_ff[0];  // R12
            end
            else if (gi == SWITCH1_PIN)
            begin : g_sw1
                assign PIN_BUFFER_OFF_OUT[gi] = pad_off_ff[gi] | switch_ff[1];  // R12
            end
            else
            begin : g_plain
                assign PIN_BUFFER_OFF_OUT[gi] = pad_off_ff[gi];  // R2 R11
            end
        end
    endgenerate

    // read data views
    assign c1_byte = {exchange_ff, ref_term_ff, ref_level_ff, power_ff, edge_ff,
                      irq_en_ff, pending_ff};
    assign c2_byte = {3'h0, short_ff, switch_ff, filter_ff, result_ff};  // R19

    // read mux
    always_comb
    begin
        // default covers unmapped addresses, which read as zero
        rd_byte = 8'h00;
        if (hit_c1)
        begin
            rd_byte = c1_byte;
        end
        else if (hit_c2)
        begin
            rd_byte = c2_byte;
        end
        else if (hit_pad)
        begin
            rd_byte = 8'(pad_off_ff);
        end
    end

    // read data registered during setup so it is steady through access
    // a write transfer leaves the last read data in place
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            PRDATA_OUT <= 32'h0000_0000;
        end
        else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
        begin
            PRDATA_OUT <= {24'h00_0000, rd_byte};
        end
    end

endmodule : acc_control

// >>> verilog/acc_defines.svh
// register offsets, field positions, reset values and timing counts for the comparator control
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
// register indices; each register owns the aligned word at four times its index
`define ACC_CTRL1_INDEX 10'h059
`define ACC_CTRL2_INDEX 10'h05a
`define ACC_PAD_INDEX 10'h05b
// register byte offsets
`define ACC_CTRL1_OFFSET {`ACC_CTRL1_INDEX, 2'h0}
`define ACC_CTRL2_OFFSET {`ACC_CTRL2_INDEX, 2'h0}
`define ACC_PAD_OFFSET {`ACC_PAD_INDEX, 2'h0}
`define ACC_ADDR_WIDTH 12
// control one fields
`define ACC_C1_PENDING 0
`define ACC_C1_IRQ_EN 1
`define ACC_C1_EDGE 2
`define ACC_C1_POWER 3
`define ACC_C1_REF_LO 4
`define ACC_C1_REF_HI 5
`define ACC_C1_REF_TERM 6
`define ACC_C1_EXCHANGE 7
// control two fields
`define ACC_C2_RESULT 0
`define ACC_C2_FILTER 1
`define ACC_C2_SWITCH0 2
`define ACC_C2_SWITCH1 3
`define ACC_C2_SHORT 4
// reset values
`define ACC_CTRL1_RESET 8'h00
`define ACC_CTRL2_RESET 8'h00
`define ACC_PAD_RESET 8'h00
// filter settling time in ns and cycles at 8 ns
`define ACC_FILTER_NS 32
`define ACC_CLOCK_NS 8
`define ACC_FILTER_CYCLES ((`ACC_FILTER_NS + `ACC_CLOCK_NS - 1) / `ACC_CLOCK_NS)
`endif

// >>> verilog/acc_pkg.sv
// types shared by the comparator control block
package acc_pkg;
    // reference generator level choices
    typedef enum logic [1:0]
    {
        ACC_REF_OFF = 2'h0,
        ACC_REF_QUARTER = 2'h1,
        ACC_REF_HALF = 2'h2,
        ACC_REF_DIODE = 2'h3
    } acc_ref_type;
endpackage : acc_pkg

// >>> tb/acc_analog_model.sv
// behavioural analog comparator standing at the far side of the block
`timescale 1ns/100ps
module acc_analog_model
(
    // pin voltages in arbitrary steps
    input wire logic [7:0] plus_level_in,
    input wire logic [7:0] minus_level_in,
    // terminal swap from the control block
    input wire logic exchange_in,
    // raw decision, no gating: the control block owns power and inversion
    output logic raw_compare_out
);
    // swapped terminals compare the other way round
    assign raw_compare_out = exchange_in ? (minus_level_in > plus_level_in)
                                         : (plus_level_in > minus_level_in);
endmodule : acc_analog_model

// >>> tb/acc_control_monitor.sv
// assertion checker watching the comparator control ports
`timescale 1ns/100ps
module acc_control_monitor
#(
    parameter int PORT_WIDTH = 8
)
(
    // watched ports
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    input wire logic PENABLE_IN,
    input wire logic RAW_COMPARE_IN,
    input wire logic COMPARATOR_POWER_ON_OUT,
    input wire logic INPUT_EXCHANGE_OUT,
    input wire logic [1:0] INPUT_SWITCH_SELECT_OUT,
    input wire logic [PORT_WIDTH-1:0] PIN_BUFFER_OFF_OUT,
    input wire logic COMPARATOR_RESULT_OUT,
    input wire logic GLOBAL_IRQ_ENABLE_IN,
    input wire logic IRQ_SERVICED_IN,
    input wire logic IRQ_REQUEST_OUT
);
    // one clock domain, so one default clocking
    default clocking @(posedge CLOCK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    a_power_gate:
        assert property (!COMPARATOR_POWER_ON_OUT [*2] |-> !COMPARATOR_RESULT_OUT)
        else $error("result high while powered off");
    a_switch_buf:
        assert property ((INPUT_SWITCH_SELECT_OUT & ~PIN_BUFFER_OFF_OUT[1:0]) == 2'h0)
        else $error("switched pin keeps its buffer");
    a_irq_gated:
        assert property (!GLOBAL_IRQ_ENABLE_IN |-> !IRQ_REQUEST_OUT)
        else $error("request without global enable");
    a_sync_delay:
        assert property ($rose(RAW_COMPARE_IN) && !COMPARATOR_RESULT_OUT |=> !COMPARATOR_RESULT_OUT)
        else $error("result skipped synchroniser");
    a_result_follows:
        assert property ($rose(RAW_COMPARE_IN) ##1
            (RAW_COMPARE_IN && COMPARATOR_POWER_ON_OUT && !INPUT_EXCHANGE_OUT) [*8]
            |-> COMPARATOR_RESULT_OUT) else $error("result not high");
    a_exch_invert:
        assert property ($rose(RAW_COMPARE_IN) ##1
            (RAW_COMPARE_IN && COMPARATOR_POWER_ON_OUT && INPUT_EXCHANGE_OUT) [*8]
            |-> !COMPARATOR_RESULT_OUT) else $error("exchanged result not inverted");
    a_edge_sets:
        assert property ($rose(IRQ_REQUEST_OUT) && $past(GLOBAL_IRQ_ENABLE_IN) && !$past(PENABLE_IN)
            |-> $past(COMPARATOR_RESULT_OUT) != $past(COMPARATOR_RESULT_OUT, 2))
        else $error("request without result edge");
    a_service_clear:
        assert property (IRQ_SERVICED_IN && !PENABLE_IN && $stable(COMPARATOR_RESULT_OUT)
            |=> !IRQ_REQUEST_OUT) else $error("service left request up");
endmodule : acc_control_monitor

bind acc_control acc_control_monitor #(.PORT_WIDTH(PORT_WIDTH)) u_mon
(
    .CLOCK_IN(CLOCK_IN),
    .ARST_N_IN(ARST_N_IN),
    .PENABLE_IN(PENABLE_IN),
    .RAW_COMPARE_IN(RAW_COMPARE_IN),
    .COMPARATOR_POWER_ON_OUT(COMPARATOR_POWER_ON_OUT),
    .INPUT_EXCHANGE_OUT(INPUT_EXCHANGE_OUT),
    .INPUT_SWITCH_SELECT_OUT(INPUT_SWITCH_SELECT_OUT),
    .PIN_BUFFER_OFF_OUT(PIN_BUFFER_OFF_OUT),
    .COMPARATOR_RESULT_OUT(COMPARATOR_RESULT_OUT),
    .GLOBAL_IRQ_ENABLE_IN(GLOBAL_IRQ_ENABLE_IN),
    .IRQ_SERVICED_IN(IRQ_SERVICED_IN),
    .IRQ_REQUEST_OUT(IRQ_REQUEST_OUT)
);

// >>> tb/analog_comparator_control_bench.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
module analog_comparator_control_bench;
    localparam int FILT = 2; // short filter keeps the run brief
    // byte addresses: four times each register's index
    localparam logic [11:0] adr_c1 = 12'h164;
    localparam logic [11:0] adr_c2 = 12'h168;
    localparam logic [11:0] adr_pad = 12'h16c;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, global_irq_enable = 1'b0, svc = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] plus_lv = 8'h32, minus_lv = 8'h64, pins;
    logic [1:0] sw, lvl;
    logic pready, pslverr, err, raw, pwr, exch, shrt, refm, res, irq;
    int n_errors = 0;
    int comparisons = 0;
    int n0, n1;
    always #4 clk = ~clk;
    // device under test, strobes all set
    acc_control #(.FILTER_CYCLES(FILT)) dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PSTRB_IN(4'hf), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .RAW_COMPARE_IN(raw), .COMPARATOR_POWER_ON_OUT(pwr),
        .INPUT_EXCHANGE_OUT(exch), .INPUT_SHORT_OUT(shrt), .INPUT_SWITCH_SELECT_OUT(sw),
        .REFERENCE_LEVEL_SELECT_OUT(lvl), .REFERENCE_TO_MINUS_OUT(refm),
        .PIN_BUFFER_OFF_OUT(pins), .COMPARATOR_RESULT_OUT(res),
        .GLOBAL_IRQ_ENABLE_IN(global_irq_enable), .IRQ_SERVICED_IN(svc), .IRQ_REQUEST_OUT(irq));
    // far side: analog pins feeding the raw decision
    acc_analog_model u_pins (.plus_level_in(plus_lv), .minus_level_in(minus_lv),
        .exchange_in(exch), .raw_compare_out(raw));
    task end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; the wait on pready is bounded
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 40)
        begin
            n_errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a write landed at the last edge of the wait loop; callers look at outputs one edge later
        @(posedge clk);
    endtask : apb
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    // cycles from a pin change until the result moves
    task lat(input logic [7:0] p, output int n);
        logic old;
        old = res;
        plus_lv <= p;
        for (n = 0; n < 30; n++)
        begin
            @(posedge clk);
            #1;
            if (res !== old) break;
        end
        if (n == 30)
        begin
            n_errors++;
            end_of_test();
        end
    endtask : lat
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(adr_c1, 32'h0);
        rdchk(adr_c2, 32'h0);
        rdchk(adr_pad, 32'h0);
        apb(1'b1, adr_pad, 32'ha4);
        rdchk(adr_pad, 32'ha4);
        check(pins, 8'ha4);
        apb(1'b1, adr_c2, 32'h04); // first switch alone
        check(sw, 2'h1);
        check(pins, 8'ha5);
        apb(1'b1, adr_c2, 32'h08); // second switch alone
        check(sw, 2'h2);
        check(pins, 8'ha6);
        apb(1'b1, adr_c2, 32'h0d); // switches on, result bit poked
        rdchk(adr_c2, 32'h0c);
        check(pins, 8'ha7);
        apb(1'b1, adr_c2, 32'h0);
        check(pins, 8'ha4);
        rdchk(12'h00c, 32'h0);
        check(err, 1'b1);
        plus_lv <= 8'hc8; // powered off, pins say high
        repeat (8) @(posedge clk);
        check(res, 1'b0);
        plus_lv <= 8'h32;
        apb(1'b1, adr_c1, 32'h0a); // power, irq enable, rising
        check(pwr, 1'b1);
        global_irq_enable <= 1'b1;
        lat(8'hc8, n0);
        check(res, 1'b1);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        global_irq_enable <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check(irq, 1'b0);
        global_irq_enable <= 1'b1;
        svc <= 1'b1;
        @(posedge clk);
        svc <= 1'b0;
        @(posedge clk);
        check(irq, 1'b0);
        apb(1'b1, adr_c1, 32'h0e); // falling edge now
        apb(1'b1, adr_c2, 32'h12); // filter and short on
        check(shrt, 1'b1);
        lat(8'h32, n1);
        check(n1, n0 + FILT);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        apb(1'b1, adr_c1, 32'h0e);
        @(posedge clk);
        check(irq, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, adr_c1, 32'(i * 16 + 8));
            check(lvl, i[1:0]);
        end
        minus_lv <= 8'h32;
        apb(1'b1, adr_c1, 32'h88); // exchange, equal pins
        check(exch, 1'b1);
        lat(8'h32, n1);
        check(res, 1'b1);
        check(refm, 1'b1);
        apb(1'b1, adr_c1, 32'hc8);
        check(refm, 1'b0);
        minus_lv <= 8'h64;
        repeat (12) @(posedge clk);
        check(res, 1'b0);
        end_of_test();
    end
endmodule : analog_comparator_control_bench
